/* verilog/sswd_pkg.sv */
// Constants and carrier types shared by the supply supervisor watchdog core
package sswd_pkg;

  // ==========================================================
  // Time base
  localparam int unsigned SSWD_SYS_CLK_HZ = 200_000_000;
  localparam int unsigned SSWD_OSC_HZ = 10_240;
  // Cycles of sys_clk per internal oscillator period, rounded down
  localparam int unsigned SSWD_OSC_DIV_CYCLES = SSWD_SYS_CLK_HZ / SSWD_OSC_HZ;

  // ==========================================================
  // Periods and threshold in their own unit, as printed
  localparam int unsigned SSWD_RESET_STD_MS = 50;
  localparam int unsigned SSWD_RESET_LONG_MS = 200;
  localparam int unsigned SSWD_WD_FAST_MS = 100;
  localparam int unsigned SSWD_WD_SLOW_MS = 1600;
  localparam int unsigned SSWD_WD_AFTER_RESET_MS = 1600;
  localparam int unsigned SSWD_PFI_THRESHOLD_MV = 1300;

  // External clock periods, in timing input cycles
  localparam int unsigned SSWD_EXT_WD_NORMAL_CLKS = 1024;
  localparam int unsigned SSWD_EXT_WD_AFTER_RESET_CLKS = 4096;
  localparam int unsigned SSWD_EXT_RESET_STD_CLKS = 512;
  localparam int unsigned SSWD_EXT_RESET_LONG_CLKS = 2048;

  localparam int unsigned SSWD_TICK_W = 15;

  typedef logic [SSWD_TICK_W-1:0] sswd_ticks_t;

  // Milliseconds to internal oscillator ticks
  function automatic sswd_ticks_t sswd_ms_to_ticks(input int unsigned ms);
    int unsigned t;
    t = (ms * SSWD_OSC_HZ) / 1000;
    return t[SSWD_TICK_W-1:0];
  endfunction

  localparam sswd_ticks_t SSWD_INT_RESET_STD = sswd_ms_to_ticks(
    SSWD_RESET_STD_MS);
  localparam sswd_ticks_t SSWD_INT_RESET_LONG = sswd_ms_to_ticks(
    SSWD_RESET_LONG_MS);
  localparam sswd_ticks_t SSWD_INT_WD_FAST = sswd_ms_to_ticks(
    SSWD_WD_FAST_MS);
  localparam sswd_ticks_t SSWD_INT_WD_SLOW = sswd_ms_to_ticks(
    SSWD_WD_SLOW_MS);
  localparam sswd_ticks_t SSWD_INT_WD_AFTER = sswd_ms_to_ticks(
    SSWD_WD_AFTER_RESET_MS);
  localparam sswd_ticks_t SSWD_EXT_WD_NORMAL =
    SSWD_EXT_WD_NORMAL_CLKS[SSWD_TICK_W-1:0];
  localparam sswd_ticks_t SSWD_EXT_WD_AFTER =
    SSWD_EXT_WD_AFTER_RESET_CLKS[SSWD_TICK_W-1:0];
  localparam sswd_ticks_t SSWD_EXT_RESET_STD =
    SSWD_EXT_RESET_STD_CLKS[SSWD_TICK_W-1:0];
  localparam sswd_ticks_t SSWD_EXT_RESET_LONG =
    SSWD_EXT_RESET_LONG_CLKS[SSWD_TICK_W-1:0];

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic supply_below_reset;
    logic supply_below_battery;
    logic power_fail_sense_low;
  } sswd_supply_t;

  typedef struct packed {
    logic high;
    logic low;
    logic mid;
  } sswd_kick_t;

  typedef enum logic [1:0] {
    SSWD_ST_HOLD,
    SSWD_ST_RUN
  } sswd_state_t;

endpackage

/* verilog/sswd_core.sv */
// Supply supervisor watchdog digital core
`timescale 1ns/10ps
// Contract
// - Power-fail warning low while sense input is below threshold, else high.
// - Supply below battery disables comparator and forces warning low.
// - Above reset threshold, gated chip select follows chip select input.
// - Below reset threshold, gated chip select held high.
// - Battery-selected high while backed-up output fed from battery.
// - Low-supply output low below threshold, high at once above.
// - Active-high reset is always inverse of active-low reset.
// - Time base select high uses internal oscillator for all periods.
// - Time base select low uses timing input as time base.
// - Internal mode reset period 50 ms, or 200 ms long variant.
// - Internal mode timing input level picks 100 ms or 1.6 s timeout.
// - Timeout right after a reset ends is nominally 1.6 s.
// - Watchdog status goes low when kick stays level past timeout.
// - Watchdog status returns high on next kick transition.
// - Kick at mid level disables watchdog, status stays high.
// - Watchdog status forced high whenever low-supply output is low.
// - Reset asserts on low supply or watchdog timeout, held period after.
// - Every kick transition restarts the watchdog count.
// - External clock: 1024 normal, 4096 after reset, 512/2048 reset.
// - Short timeout starts only after first kick transition after reset.
module sswd_core
  import sswd_pkg::*;
#(
  parameter bit LONG_RESET = 1'b0,
  parameter int unsigned OSC_DIV_CYCLES = sswd_pkg::SSWD_OSC_DIV_CYCLES
)
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire sswd_pkg::sswd_supply_t supply,
  input wire sswd_pkg::sswd_kick_t watchdog_kick,
  input wire logic timebase_select,
  input wire logic timing_input,
  input wire logic chip_select_in_n,
  output logic chip_select_out_n,
  output logic power_fail_warning_n,
  output logic battery_selected,
  output logic low_supply_n,
  output logic cpu_reset_n,
  output logic cpu_reset,
  output logic watchdog_status_n
);
  import sswd_pkg::*;

  localparam int unsigned DIV_W = $clog2(OSC_DIV_CYCLES + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;
  localparam sswd_ticks_t TICK_ZERO = '0;
  localparam sswd_ticks_t TICK_ONE = 15'h0001;

  // Terminal count test shared by the reset and watchdog timers
  function automatic logic period_done(
    input sswd_ticks_t count,
    input sswd_ticks_t period
  );
    return (count + TICK_ONE) >= period;
  endfunction

  // ==========================================================
  // Time base
  logic [DIV_W-1:0] div_reg;
  logic timing_prev_reg;
  logic tick;
  logic int_tick;
  logic ext_tick;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      div_reg <= DIV_ZERO;
    else if (div_reg == DIV_LAST)
      div_reg <= DIV_ZERO;
    else
      div_reg <= div_reg + 1'b1;
  end

  always_ff @(posedge sys_clk)
  begin
    // Seeded from the pin so a high level at release is not an edge
    if (!reset_n)
      timing_prev_reg <= timing_input;
    else
      timing_prev_reg <= timing_input;
  end

  assign int_tick = (div_reg == DIV_LAST);
  // External clock or capacitor oscillation: one tick per rising edge
  assign ext_tick = timing_input && !timing_prev_reg;
  assign tick = timebase_select ? int_tick : ext_tick;

  // ==========================================================
  // Period selection
  sswd_ticks_t reset_period;
  sswd_ticks_t wd_period;
  logic long_timeout_reg;

  always_comb
  begin
    if (timebase_select)
    begin
      reset_period = LONG_RESET ? SSWD_INT_RESET_LONG
                                : SSWD_INT_RESET_STD;
      if (long_timeout_reg)
        wd_period = SSWD_INT_WD_AFTER;
      else if (!timing_input)
        wd_period = SSWD_INT_WD_FAST;
      else
        wd_period = SSWD_INT_WD_SLOW;
    end
    else
    begin
      reset_period = LONG_RESET ? SSWD_EXT_RESET_LONG
                                : SSWD_EXT_RESET_STD;
      wd_period = long_timeout_reg ? SSWD_EXT_WD_AFTER
                                   : SSWD_EXT_WD_NORMAL;
    end
  end

  // ==========================================================
  // Kick transition detection
  logic kick_level_reg;
  logic kick_valid_reg;
  logic kick_edge;
  logic kick_active;

  assign kick_active = (watchdog_kick.high || watchdog_kick.low)
                       && !watchdog_kick.mid;

  // A return from mid level is not counted as a transition
  assign kick_edge = kick_active && kick_valid_reg
                     && (watchdog_kick.high != kick_level_reg);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      kick_valid_reg <= 1'b0;
    else
      kick_valid_reg <= kick_active;
  end

  // Last driven level, kept across a mid-level spell
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      kick_level_reg <= 1'b0;
    else if (kick_active)
      kick_level_reg <= watchdog_kick.high;
  end

  // ==========================================================
  // Reset sequencer
  sswd_state_t state_reg;
  sswd_ticks_t rst_count_reg;
  sswd_ticks_t wd_count_reg;
  logic supply_fault;
  logic wd_expire;
  logic hold_done;
  logic rst_out_reg;

  assign supply_fault = supply.supply_below_reset
                        || supply.supply_below_battery;
  assign wd_expire = (state_reg == SSWD_ST_RUN) && kick_active && tick
                     && period_done(wd_count_reg, wd_period);
  // Last tick of a fault-free reset period
  assign hold_done = (state_reg == SSWD_ST_HOLD) && !supply_fault && tick
                     && period_done(rst_count_reg, reset_period);

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      state_reg <= SSWD_ST_HOLD;
    else
    begin
      unique case (state_reg)
        SSWD_ST_HOLD:
        begin
          if (hold_done)
            state_reg <= SSWD_ST_RUN;
        end
        SSWD_ST_RUN:
        begin
          if (supply_fault || wd_expire)
            state_reg <= SSWD_ST_HOLD;
        end
      endcase
    end
  end

  // Any fault restarts the full reset period, it does not just pause it
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      rst_count_reg <= TICK_ZERO;
    else if (state_reg != SSWD_ST_HOLD || supply_fault || hold_done)
      rst_count_reg <= TICK_ZERO;
    else if (tick)
      rst_count_reg <= rst_count_reg + TICK_ONE;
  end

  // Reset pins come from a flop that tracks the next state, so they
  // switch on the same edge as the sequencer and cannot glitch
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      rst_out_reg <= 1'b0;
    else if (state_reg == SSWD_ST_HOLD)
      rst_out_reg <= hold_done;
    else
      rst_out_reg <= !(supply_fault || wd_expire);
  end

  // ==========================================================
  // Watchdog counter
  logic wd_clear;

  // Mid level parks the count at zero; any edge restarts it
  assign wd_clear = (state_reg != SSWD_ST_RUN) || kick_edge
                    || !kick_active;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      wd_count_reg <= TICK_ZERO;
    else if (wd_clear)
      wd_count_reg <= TICK_ZERO;
    else if (tick)
      wd_count_reg <= wd_count_reg + TICK_ONE;
  end

  // Long timeout armed while in reset, dropped by first kick after it
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      long_timeout_reg <= 1'b1;
    else if (state_reg == SSWD_ST_HOLD)
      long_timeout_reg <= 1'b1;
    else if (kick_edge)
      long_timeout_reg <= 1'b0;
  end

  // ==========================================================
  // Watchdog status
  logic wd_status_reg;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      wd_status_reg <= 1'b1;
    else if (supply.supply_below_reset)
      wd_status_reg <= 1'b1;
    else if (!kick_active)
      wd_status_reg <= 1'b1;
    else if (wd_expire)
      wd_status_reg <= 1'b0;
    else if (kick_edge)
      wd_status_reg <= 1'b1;
  end

  // ==========================================================
  // Status outputs
  logic pfw_reg;
  logic batt_reg;
  logic low_reg;

  // Comparator is off when running from battery
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      pfw_reg <= 1'b0;
    else
      pfw_reg <= !supply.power_fail_sense_low
                 && !supply.supply_below_battery;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      batt_reg <= 1'b0;
    else
      batt_reg <= supply.supply_below_battery;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      low_reg <= 1'b0;
    else
      low_reg <= !supply.supply_below_reset;
  end

  // Gating stays combinational so memory sees no added latency
  assign chip_select_out_n = supply.supply_below_reset ? 1'b1
                             : chip_select_in_n;

  assign power_fail_warning_n = pfw_reg;
  assign battery_selected = batt_reg;
  assign low_supply_n = low_reg;
  assign watchdog_status_n = wd_status_reg;
  assign cpu_reset_n = rst_out_reg;
  assign cpu_reset = !cpu_reset_n;

endmodule

/* verif/sswd_core_assertions.sv */
// Port-level checker for the supervisor watchdog core
`timescale 1ns/10ps
module sswd_chk
  import sswd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire sswd_pkg::sswd_supply_t supply,
  input wire sswd_pkg::sswd_kick_t watchdog_kick,
  input wire logic chip_select_in_n,
  input wire logic chip_select_out_n,
  input wire logic power_fail_warning_n,
  input wire logic battery_selected,
  input wire logic low_supply_n,
  input wire logic cpu_reset_n,
  input wire logic cpu_reset,
  input wire logic watchdog_status_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  wire logic act = watchdog_kick.high | watchdog_kick.low;
  // ==========================================================
  // Sequences
  // Two settled active cycles, so a level from before reset is ignored
  sequence s_kick_edge;
    act && $past(act) && $past(reset_n) && $past(reset_n, 2)
      && $changed(watchdog_kick.high);
  endsequence
  sequence s_expire;
    $fell(watchdog_status_n);
  endsequence
  // ==========================================================
  // Properties
  AST_RST_INV: assert property (cpu_reset == !cpu_reset_n)
    else $error("active-high reset not inverse of active-low");
  AST_CS_HOLD: assert property (supply.supply_below_reset
    |-> chip_select_out_n) else $error("chip select not blocked");
  AST_CS_PASS: assert property (!supply.supply_below_reset
    |-> chip_select_out_n == chip_select_in_n)
    else $error("chip select not passed");
  AST_PFW: assert property (1 |=> power_fail_warning_n ==
    !($past(supply.power_fail_sense_low)
    || $past(supply.supply_below_battery)))
    else $error("power fail warning wrong");
  AST_BATT: assert property (1 |=> battery_selected ==
    $past(supply.supply_below_battery))
    else $error("battery selected wrong");
  AST_LOW: assert property (1 |=> low_supply_n ==
    !$past(supply.supply_below_reset)) else $error("low supply wrong");
  AST_WD_FORCE: assert property (supply.supply_below_reset
    |=> watchdog_status_n) else $error("status not forced high");
  AST_WD_MID: assert property (watchdog_kick.mid
    |=> watchdog_status_n) else $error("status low with kick parked");
  AST_FAULT: assert property (supply.supply_below_reset
    || supply.supply_below_battery |=> !cpu_reset_n)
    else $error("no reset on supply fault");
  AST_EXP: assert property (s_expire |-> !cpu_reset_n)
    else $error("timeout without reset");
  AST_KICK: assert property (s_kick_edge |=> watchdog_status_n)
    else $error("status not restored by kick edge");
endmodule

bind sswd_core sswd_chk u_chk (.sys_clk, .reset_n, .supply,
  .watchdog_kick, .chip_select_in_n, .chip_select_out_n,
  .power_fail_warning_n, .battery_selected, .low_supply_n,
  .cpu_reset_n, .cpu_reset, .watchdog_status_n);

/* verif/sswd_host_model.sv */
// Host processor model that services the watchdog kick
`timescale 1ns/10ps
module sswd_host
  import sswd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic auto_en,
  input wire logic step,
  input wire logic park_mid,
  output sswd_pkg::sswd_kick_t kick
);
  logic lvl_reg = 1'b1;
  logic [2:0] cnt_reg = 3'h0;
  // Eight-cycle toggling sits far inside the shortest timeout
  always_ff @(posedge sys_clk)
  begin
    cnt_reg <= cnt_reg + 3'h1;
    if ((auto_en && cnt_reg == 3'h7) || step)
      lvl_reg <= !lvl_reg;
  end
  // A floating kick pin decodes as the mid level only
  assign kick = park_mid ? 3'h1 : {lvl_reg, !lvl_reg, 1'b0};
endmodule

/* verif/tb.sv */
// Self-checking bench for the supervisor watchdog core
`timescale 1ns/10ps
module tb;
  import sswd_pkg::*;
  localparam int DIV = 4;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  sswd_supply_t supply = 3'h4;
  sswd_kick_t kick;
  logic tsel = 1'b0, tin = 1'b0, osc_on = 1'b0, cs_in_n = 1'b1;
  logic auto_en = 1'b0, step = 1'b0, park_mid = 1'b0;
  logic cs_out_n, pfw_n, batt, low_n, rst_n_o, rst_o, wds_n;
  int fail_count = 0, cmp_count = 0, n;
  always #2.5 sys_clk = !sys_clk;
  // External time base: one tick every two cycles
  always @(posedge sys_clk) if (osc_on) tin <= #1 !tin;
  sswd_core #(.LONG_RESET(1'b0), .OSC_DIV_CYCLES(DIV)) dut (
    .sys_clk, .reset_n, .supply, .watchdog_kick(kick),
    .timebase_select(tsel), .timing_input(tin),
    .chip_select_in_n(cs_in_n), .chip_select_out_n(cs_out_n),
    .power_fail_warning_n(pfw_n), .battery_selected(batt),
    .low_supply_n(low_n), .cpu_reset_n(rst_n_o), .cpu_reset(rst_o),
    .watchdog_status_n(wds_n));
  sswd_host host (.sys_clk, .auto_en, .step, .park_mid, .kick);
  function automatic logic exp_pfw(sswd_supply_t s);
    return !(s.power_fail_sense_low | s.supply_below_battery);
  endfunction
  task automatic cmp_bit(string nm, logic e, logic g);
    cmp_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_len(string nm, int e, int g, int tol);
    cmp_count++;
    if (g < e - tol || g > e + tol)
    begin
      fail_count++;
      $display("[ERR] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  // Cycles until reset (w=0) or status (w=1) reaches v, capped at lim
  task automatic wait_for(int w, logic v, int lim, output int c);
    c = 0;
    while (((w == 1) ? wds_n : rst_n_o) !== v && c < lim)
    begin
      cyc(1);
      c++;
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #400000;
    fail_count++;
    conclude();
  end
  initial
  begin
    void'($urandom(32'h7a1cc42c));
    cyc(16);
    reset_n = 1'b1;
    for (int i = 0; i < 60; i++)
    begin
      // Battery without sense low first: the warning must still drop
      supply = (i < 2) ? 3'h2 : 3'($urandom);
      cs_in_n = 1'($urandom);
      #1;
      cmp_bit("cs_out_n", supply[2] | cs_in_n, cs_out_n);
      cyc(1);
      cmp_bit("pfw_n", exp_pfw(supply), pfw_n);
      cmp_bit("batt", supply.supply_below_battery, batt);
      cmp_bit("low_n", !supply.supply_below_reset, low_n);
      cmp_bit("rst", !rst_n_o, rst_o);
    end
    $display("Test supply status done");
    supply = 3'h4;
    osc_on = 1'b1;
    cyc(2);
    cmp_bit("rst_n", 1'b0, rst_n_o);
    supply = 3'h0;
    wait_for(0, 1'b1, 20000, n);
    cmp_len("ext reset", 2 * SSWD_EXT_RESET_STD_CLKS, n, 4);
    wait_for(1, 1'b0, 20000, n);
    cmp_len("long wd", 2 * SSWD_EXT_WD_AFTER_RESET_CLKS, n, 4);
    cmp_bit("rst_n", 1'b0, rst_n_o);
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    cyc(2);
    cmp_bit("wds_n", 1'b1, wds_n);
    $display("Test external timing done");
    wait_for(0, 1'b1, 20000, n);
    auto_en = 1'b1;
    wait_for(0, 1'b0, 6000, n);
    cmp_len("serviced", 6000, n, 0);
    auto_en = 1'b0;
    wait_for(1, 1'b0, 20000, n);
    cmp_len("short wd", 2 * SSWD_EXT_WD_NORMAL_CLKS, n, 12);
    wait_for(0, 1'b1, 20000, n);
    park_mid = 1'b1;
    cyc(2);
    cmp_bit("wds_n parked", 1'b1, wds_n);
    wait_for(1, 1'b0, 10000, n);
    cmp_len("parked", 10000, n, 0);
    cmp_bit("rst_n parked", 1'b1, rst_n_o);
    park_mid = 1'b0;
    $display("Test servicing done");
    osc_on = 1'b0;
    // Let the last delayed toggle land before taking the pin over
    cyc(1);
    tsel = 1'b1;
    tin = 1'b1;
    supply = 3'h4;
    cyc(2);
    supply = 3'h0;
    wait_for(0, 1'b1, 20000, n);
    cmp_len("int reset", 512 * DIV, n, DIV + 2);
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    // Slow period still running well past the fast limit
    wait_for(1, 1'b0, 1024 * DIV + 64, n);
    cmp_len("slow wd", 1024 * DIV + 64, n, 0);
    step = 1'b1;
    cyc(1);
    step = 1'b0;
    cyc(1);
    tin = 1'b0;
    wait_for(1, 1'b0, 20000, n);
    cmp_len("fast wd", 1024 * DIV, n, DIV + 12);
    $display("Test internal timing done");
    conclude();
  end
endmodule
